/* File: ltab_bank.sv */
// limit threshold register bank with diagnostic flags and interrupt
//
// What this block does
// R1: trim checksum ok bit resets to one, drops to zero on checksum error.
// R2: shunt over limit, signed sixteen bits, reset 7fff, signed compare per shunt result.
// R3: negative shunt over limit trips on a zero volt shunt result.
// R4: software sets shunt over limit to the larger of two negative limits.
// R5: shunt under limit, signed sixteen bits, reset 8000, signed compare per result.
// R6: shunt limits share shunt result scaling, chosen by the input range select.
// R7: bus over limit in bits 14 to 0, unsigned, reset 7fff, bit 15 reads zero.
// R8: bus under limit in bits 14 to 0, unsigned, reset zero, bit 15 reads zero.
// R9: bus limits compare directly against raw bus result codes.
// R10: temperature limit bits 15 to 4, signed, reset 7ff, compared to die temperature.
// R11: temperature limit bits 3 to 0 always read zero.
// R12: power over limit at address 11, reset ffff.
// R13: each result beyond its limit sets the matching diagnostic flag.
// R14: in latched mode flags hold until software reads the diagnostic register.
// R15: power limit is unsigned sixteen bits, compared to bits 23 to 8 of the power result.
// R16: every compare runs on each new result with the limits held then.
`timescale 1ns/1ps
`default_nettype none

module ltab_bank
  import ltab_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire ltab_bus_req_t     reg_req,
  output logic [DATA_W-1:0]      reg_rdata,
  // measurement results
  input  wire ltab_meas_t        meas,
  input  wire logic              trim_checksum_error,
  // status and control outputs
  output logic [DIAG_USED_W-1:0] diagnostic_alert_flags,
  output logic                   shunt_input_range_select,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]      shunt_over_limit;
  logic [DATA_W-1:0]      shunt_under_limit;
  logic [BUS_LIMIT_W-1:0] bus_over_limit;
  logic [BUS_LIMIT_W-1:0] bus_under_limit;
  logic [TEMP_W-1:0]      temperature_over_limit_field;
  logic [DATA_W-1:0]      power_over_limit;
  logic [CFG_W-1:0]       config_bits;
  logic [NUM_CH-1:0]      limit_flag;
  logic [NUM_CH-1:0]      irq_status;
  logic [NUM_CH-1:0]      irq_mask;
  logic                   trim_checksum_ok;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  wire logic wr_shunt_over  = reg_req.wr && (reg_req.addr == ADDR_SHUNT_OVER);
  wire logic wr_shunt_under = reg_req.wr && (reg_req.addr == ADDR_SHUNT_UNDER);
  wire logic wr_bus_over    = reg_req.wr && (reg_req.addr == ADDR_BUS_OVER);
  wire logic wr_bus_under   = reg_req.wr && (reg_req.addr == ADDR_BUS_UNDER);
  wire logic wr_temp_over   = reg_req.wr && (reg_req.addr == ADDR_TEMP_OVER);
  wire logic wr_power_over  = reg_req.wr && (reg_req.addr == ADDR_POWER_OVER); // R12
  wire logic wr_config      = reg_req.wr && (reg_req.addr == ADDR_CONFIG);
  wire logic wr_irq_status  = reg_req.wr && (reg_req.addr == ADDR_IRQ_STATUS);
  wire logic wr_irq_mask    = reg_req.wr && (reg_req.addr == ADDR_IRQ_MASK);
  wire logic rd_diag        = reg_req.rd && (reg_req.addr == ADDR_DIAG);

  // write data slices in the status and mask layout
  wire logic [NUM_CH-1:0] wdata_flags = reg_req.wdata[FLAG_LSB +: NUM_CH];

  // mode bits
  wire logic alert_latch_select = config_bits[CFG_LATCH_BIT];
  assign shunt_input_range_select = config_bits[CFG_RANGE_BIT]; // R6

  // ---------------------------------------------------------------
  // shunt limits, full sixteen bit signed fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shunt_over_limit  <= RST_SHUNT_OVER; // R2
      shunt_under_limit <= RST_SHUNT_UNDER; // R5
    end else begin
      if (wr_shunt_over) shunt_over_limit <= reg_req.wdata; // R2
      if (wr_shunt_under) shunt_under_limit <= reg_req.wdata; // R5
    end
  end

  // ---------------------------------------------------------------
  // bus limits, bit 15 never stored
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_over_limit  <= RST_BUS_OVER; // R7
      bus_under_limit <= RST_BUS_UNDER; // R8
    end else begin
      if (wr_bus_over) bus_over_limit <= reg_req.wdata[BUS_LIMIT_W-1:0]; // R7
      if (wr_bus_under) bus_under_limit <= reg_req.wdata[BUS_LIMIT_W-1:0]; // R8
    end
  end

  // ---------------------------------------------------------------
  // temperature and power limits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      temperature_over_limit_field <= RST_TEMP_OVER; // R10
      power_over_limit             <= RST_POWER_OVER; // R12
    end else begin
      if (wr_temp_over) begin
        temperature_over_limit_field <= reg_req.wdata[TEMP_LSB +: TEMP_W]; // R10
      end
      if (wr_power_over) power_over_limit <= reg_req.wdata; // R15
    end
  end

  // ---------------------------------------------------------------
  // config, interrupt mask
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config_bits <= '0;
      irq_mask    <= '0;
    end else begin
      if (wr_config) config_bits <= reg_req.wdata[CFG_W-1:0];
      if (wr_irq_mask) irq_mask <= wdata_flags;
    end
  end

  // ---------------------------------------------------------------
  // comparisons, one per measurement kind
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] cmp_hit;
  logic [NUM_CH-1:0] cmp_valid;

  // signed shunt compare, so a negative over limit trips at zero volts
  ltab_limit_cmp #(.W(DATA_W), .IS_SIGNED(1'b1)) u_shunt_cmp (
    .result      (meas.shunt_result),
    .over_limit  (shunt_over_limit),
    .under_limit (shunt_under_limit),
    .over_hit    (cmp_hit[CH_SHUNT_OVER]),  // R2 R3
    .under_hit   (cmp_hit[CH_SHUNT_UNDER])  // R5
  );

  // raw bus codes against zero-extended limits
  ltab_limit_cmp #(.W(DATA_W), .IS_SIGNED(1'b0)) u_bus_cmp (
    .result      (meas.bus_result),
    .over_limit  ({1'b0, bus_over_limit}),
    .under_limit ({1'b0, bus_under_limit}),
    .over_hit    (cmp_hit[CH_BUS_OVER]),  // R9
    .under_hit   (cmp_hit[CH_BUS_UNDER])  // R9
  );

  // signed twelve bit die temperature, over limit only
  ltab_limit_cmp #(.W(TEMP_W), .IS_SIGNED(1'b1)) u_temp_cmp (
    .result      (meas.die_temperature_result),
    .over_limit  (temperature_over_limit_field),
    .under_limit (temperature_over_limit_field),
    .over_hit    (cmp_hit[CH_TEMP_OVER]),  // R10
    .under_hit   ()
  );

  // unsigned power, limit weighs in at the power result's upper word
  ltab_limit_cmp #(.W(DATA_W), .IS_SIGNED(1'b0)) u_power_cmp (
    .result      (meas.power_result[POWER_LSB +: DATA_W]),
    .over_limit  (power_over_limit),
    .under_limit (power_over_limit),
    .over_hit    (cmp_hit[CH_POWER_OVER]),  // R15
    .under_hit   ()
  );

  // each channel samples only when its own result is new
  assign cmp_valid[CH_SHUNT_OVER]  = meas.shunt_valid; // R16
  assign cmp_valid[CH_SHUNT_UNDER] = meas.shunt_valid; // R16
  assign cmp_valid[CH_BUS_OVER]    = meas.bus_valid; // R16
  assign cmp_valid[CH_BUS_UNDER]   = meas.bus_valid; // R16
  assign cmp_valid[CH_TEMP_OVER]   = meas.temp_valid; // R16
  assign cmp_valid[CH_POWER_OVER]  = meas.power_valid; // R16

  // ---------------------------------------------------------------
  // diagnostic flags and interrupt status, per channel
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] limit_event;
  logic [NUM_CH-1:0] next_limit_flag;
  logic [NUM_CH-1:0] next_irq_status;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_chan
      // a new result beyond its limit
      assign limit_event[ch] = cmp_valid[ch] & cmp_hit[ch]; // R13
      // latched: set wins over the clearing read; transparent: follow each result
      assign next_limit_flag[ch] = alert_latch_select ?
          (limit_event[ch] | (limit_flag[ch] & ~rd_diag)) : // R14
          (cmp_valid[ch] ? cmp_hit[ch] : limit_flag[ch]); // R13
      // write one to clear, a same cycle event wins
      assign next_irq_status[ch] = limit_event[ch] |
          (irq_status[ch] & ~(wr_irq_status & wdata_flags[ch]));
    end
  endgenerate

  // flag and status registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      limit_flag <= '0;
      irq_status <= '0;
    end else begin
      limit_flag <= next_limit_flag; // R13 R14
      irq_status <= next_irq_status;
    end
  end

  // trim checksum status, sticky low once an error is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trim_checksum_ok <= 1'b1; // R1
    end else if (trim_checksum_error) begin
      trim_checksum_ok <= 1'b0; // R1
    end
  end

  // level interrupt from any unmasked status bit
  assign irq = |(irq_status & irq_mask);

  // diagnostic view: flags over bits 7 to 2, trim status in bit 0
  assign diagnostic_alert_flags = {limit_flag, 1'b0, trim_checksum_ok};

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  // select the addressed word, reserved bits and unmapped words read zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_req.addr)
      ADDR_SHUNT_OVER:  rd_mux = shunt_over_limit;
      ADDR_SHUNT_UNDER: rd_mux = shunt_under_limit;
      ADDR_BUS_OVER:    rd_mux = {1'b0, bus_over_limit}; // R7
      ADDR_BUS_UNDER:   rd_mux = {1'b0, bus_under_limit}; // R8
      ADDR_TEMP_OVER:   rd_mux = {temperature_over_limit_field, {TEMP_LSB{1'b0}}}; // R11
      ADDR_POWER_OVER:  rd_mux = power_over_limit;
      ADDR_DIAG:        rd_mux = {{(DATA_W-DIAG_USED_W){1'b0}}, diagnostic_alert_flags};
      ADDR_CONFIG:      rd_mux = {{(DATA_W-CFG_W){1'b0}}, config_bits};
      ADDR_IRQ_STATUS:  rd_mux = {{(DATA_W-DIAG_USED_W){1'b0}}, irq_status, {FLAG_LSB{1'b0}}};
      ADDR_IRQ_MASK:    rd_mux = {{(DATA_W-DIAG_USED_W){1'b0}}, irq_mask, {FLAG_LSB{1'b0}}};
      default:          rd_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_req.rd ? rd_mux : '0;
    end
  end

endmodule

`default_nettype wire

/* File: ltab_bank_monitor.sv */
// assertion checker for the limit threshold alert bank ports
`timescale 1ns/1ps
`default_nettype none

module ltab_bank_monitor
  import ltab_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // register port
  input  wire ltab_bus_req_t          reg_req,
  input  wire logic [DATA_W-1:0]      reg_rdata,
  // measurements
  input  wire ltab_meas_t             meas,
  input  wire logic                   trim_checksum_error,
  // watched outputs
  input  wire logic [DIAG_USED_W-1:0] diagnostic_alert_flags,
  input  wire logic                   shunt_input_range_select,
  input  wire logic                   irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  // one read strobe at a given address
  sequence rd_at(logic [ADDR_W-1:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // single bits of the diagnostic view and the config write strobe
  wire logic trim_checksum_ok      = diagnostic_alert_flags[TRIM_BIT];
  wire logic shunt_over_flag       = diagnostic_alert_flags[FLAG_LSB + CH_SHUNT_OVER];
  wire logic bus_over_flag         = diagnostic_alert_flags[FLAG_LSB + CH_BUS_OVER];
  wire logic temperature_over_flag = diagnostic_alert_flags[FLAG_LSB + CH_TEMP_OVER];
  wire logic power_over_flag       = diagnostic_alert_flags[FLAG_LSB + CH_POWER_OVER];
  wire logic config_write          = reg_req.wr && reg_req.addr == ADDR_CONFIG;

  trim_drop_a: assert property (trim_checksum_error |=> !trim_checksum_ok)
    else $error("trim ok bit did not drop after checksum error");
  trim_hold_a: assert property (!trim_checksum_ok |=> !trim_checksum_ok)
    else $error("trim ok bit recovered without reset");
  bus_over_rsvd_a: assert property (rd_at(ADDR_BUS_OVER) |=> reg_rdata[15] == 1'b0)
    else $error("bus over limit bit 15 read as one");
  bus_under_rsvd_a: assert property (rd_at(ADDR_BUS_UNDER) |=> reg_rdata[15] == 1'b0)
    else $error("bus under limit bit 15 read as one");
  temp_nibble_a: assert property (rd_at(ADDR_TEMP_OVER) |=> reg_rdata[3:0] == 4'h0)
    else $error("temperature limit low nibble not zero");
  shunt_rise_a: assert property ($rose(shunt_over_flag) |-> $past(meas.shunt_valid))
    else $error("shunt over flag rose without a shunt result");
  bus_rise_a: assert property ($rose(bus_over_flag) |-> $past(meas.bus_valid))
    else $error("bus over flag rose without a bus result");
  temp_rise_a: assert property ($rose(temperature_over_flag) |-> $past(meas.temp_valid))
    else $error("temperature flag rose without a result");
  power_rise_a: assert property ($rose(power_over_flag) |-> $past(meas.power_valid))
    else $error("power flag rose without a power result");
  range_chg_a: assert property ($changed(shunt_input_range_select) |-> $past(config_write))
    else $error("range select changed without a config write");
endmodule

bind ltab_bank ltab_bank_monitor u_mon (
  .clk                      (clk),
  .reset                    (reset),
  .reg_req                  (reg_req),
  .reg_rdata                (reg_rdata),
  .meas                     (meas),
  .trim_checksum_error      (trim_checksum_error),
  .diagnostic_alert_flags   (diagnostic_alert_flags),
  .shunt_input_range_select (shunt_input_range_select),
  .irq                      (irq)
);

`default_nettype wire

/* File: ltab_limit_cmp.sv */
// over and under comparison of one result against its two limits
`timescale 1ns/1ps
`default_nettype none

module ltab_limit_cmp #(
  parameter int W         = 16,
  parameter bit IS_SIGNED = 1'b1
) (
  // operands
  input  wire logic [W-1:0] result,
  input  wire logic [W-1:0] over_limit,
  input  wire logic [W-1:0] under_limit,
  // outcome
  output logic              over_hit,
  output logic              under_hit
);

  // extend by one bit so one signed compare serves both number kinds
  wire logic [W:0] result_x = {IS_SIGNED & result[W-1], result};
  wire logic [W:0] over_x   = {IS_SIGNED & over_limit[W-1], over_limit};
  wire logic [W:0] under_x  = {IS_SIGNED & under_limit[W-1], under_limit};

  // strict compares: equal to a limit is still in range
  assign over_hit  = $signed(result_x) > $signed(over_x);
  assign under_hit = $signed(result_x) < $signed(under_x);

endmodule

`default_nettype wire

/* File: ltab_pkg.sv */
// constants, register map and carrier types of the limit threshold alert bank
package ltab_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SHUNT_OVER  = 6'h0c;
  localparam logic [ADDR_W-1:0] ADDR_SHUNT_UNDER = 6'h0d;
  localparam logic [ADDR_W-1:0] ADDR_BUS_OVER    = 6'h0e;
  localparam logic [ADDR_W-1:0] ADDR_BUS_UNDER   = 6'h0f;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_OVER   = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_POWER_OVER  = 6'h11;
  localparam logic [ADDR_W-1:0] ADDR_DIAG        = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG      = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 6'h22;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 6'h23;

  // ---------------------------------------------------------------
  // reset values and field shapes
  // ---------------------------------------------------------------
  localparam int BUS_LIMIT_W = 15;
  localparam int TEMP_W      = 12;
  localparam int TEMP_LSB    = 4;
  localparam int POWER_W     = 24;
  localparam int POWER_LSB   = 8;
  localparam logic [DATA_W-1:0]      RST_SHUNT_OVER  = 16'h7fff;
  localparam logic [DATA_W-1:0]      RST_SHUNT_UNDER = 16'h8000;
  localparam logic [BUS_LIMIT_W-1:0] RST_BUS_OVER    = 15'h7fff;
  localparam logic [BUS_LIMIT_W-1:0] RST_BUS_UNDER   = 15'h0000;
  localparam logic [TEMP_W-1:0]      RST_TEMP_OVER   = 12'h7ff;
  localparam logic [DATA_W-1:0]      RST_POWER_OVER  = 16'hffff;

  // ---------------------------------------------------------------
  // limit channels, in diagnostic bit order from bit FLAG_LSB up
  // ---------------------------------------------------------------
  localparam int NUM_CH         = 6;
  localparam int CH_POWER_OVER  = 0;
  localparam int CH_BUS_UNDER   = 1;
  localparam int CH_BUS_OVER    = 2;
  localparam int CH_SHUNT_UNDER = 3;
  localparam int CH_SHUNT_OVER  = 4;
  localparam int CH_TEMP_OVER   = 5;
  localparam int FLAG_LSB       = 2;
  localparam int TRIM_BIT       = 0;
  localparam int DIAG_USED_W    = FLAG_LSB + NUM_CH;

  // config register bits
  localparam int CFG_LATCH_BIT = 0;
  localparam int CFG_RANGE_BIT = 1;
  localparam int CFG_W         = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ltab_bus_req_t;

  typedef struct packed {
    logic               shunt_valid;
    logic [DATA_W-1:0]  shunt_result;
    logic               bus_valid;
    logic [DATA_W-1:0]  bus_result;
    logic               temp_valid;
    logic [TEMP_W-1:0]  die_temperature_result;
    logic               power_valid;
    logic [POWER_W-1:0] power_result;
  } ltab_meas_t;

endpackage

/* File: tb_top.sv */
// self-checking bench for the limit threshold alert bank
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ltab_pkg::*;
;
  logic                   clk;
  logic                   reset;
  ltab_bus_req_t          reg_req;
  logic [DATA_W-1:0]      reg_rdata;
  ltab_meas_t             meas;
  logic                   trim_checksum_error;
  logic [DIAG_USED_W-1:0] flags;
  logic                   range_sel;
  logic                   irq;
  int                     err_count;
  int                     checks_done;
  logic [ADDR_W-1:0]      lim_addr [6] = '{ADDR_SHUNT_OVER, ADDR_SHUNT_UNDER, ADDR_BUS_OVER,
                                           ADDR_BUS_UNDER, ADDR_TEMP_OVER, ADDR_POWER_OVER};
  logic [DATA_W-1:0]      lim_rst [6] = '{16'h7fff, 16'h8000, 16'h7fff, 16'h0000, 16'h7ff0,
                                          16'hffff};
  logic [DATA_W-1:0]      lim_full [6] = '{16'hffff, 16'hffff, 16'h7fff, 16'h7fff, 16'hfff0,
                                           16'hffff};

  ltab_bank dut (
    .clk                      (clk),
    .reset                    (reset),
    .reg_req                  (reg_req),
    .reg_rdata                (reg_rdata),
    .meas                     (meas),
    .trim_checksum_error      (trim_checksum_error),
    .diagnostic_alert_flags   (flags),
    .shunt_input_range_select (range_sel),
    .irq                      (irq)
  );

  // ---------------------------------------------------------------
  // clock, watchdog and tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end

  task automatic final_report();
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(negedge clk);
    chk(exp, reg_rdata);
  endtask

  // one-cycle result pulse; sel bits pick shunt, bus, temperature, power
  task automatic hit(input logic [3:0] sel, input logic [POWER_W-1:0] v);
    @(posedge clk);
    meas <= '{sel[0], v[15:0], sel[1], v[15:0], sel[2], v[11:0], sel[3], v};
    @(posedge clk);
    meas <= '0;
  endtask

  task automatic flg(input logic [7:0] e);
    @(negedge clk);
    chk({8'h00, e}, {8'h00, flags});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    err_count = 0;
    checks_done = 0;
    reg_req = '0;
    meas = '0;
    trim_checksum_error = 1'b0;
    reset = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // reset values, then all-ones writes with reserved bits dropped
    for (int i = 0; i < 6; i++) rd(lim_addr[i], lim_rst[i]);
    for (int i = 0; i < 6; i++) wr(lim_addr[i], 16'hffff);
    for (int i = 0; i < 6; i++) rd(lim_addr[i], lim_full[i]);
    rd(6'h3f, 16'h0000);
    rd(ADDR_DIAG, 16'h0001);
    // transparent mode compares with limits at minus one and maximum
    hit(4'h1, 24'h000000);
    flg(8'h41);
    hit(4'h2, 24'h000001);
    flg(8'h49);
    hit(4'h4, 24'h000000);
    flg(8'hc9);
    hit(4'h8, 24'hffff00);
    flg(8'hc9);
    hit(4'h1, 24'h008000);
    flg(8'ha9);
    rd(ADDR_DIAG, 16'h00a9);
    flg(8'ha9);
    // interrupt masked, unmasked and cleared
    chk(16'h0000, {15'h0, irq});
    wr(ADDR_IRQ_MASK, 16'h0020);
    @(negedge clk);
    chk(16'h0001, {15'h0, irq});
    rd(ADDR_IRQ_STATUS, 16'h00e8);
    wr(ADDR_IRQ_STATUS, 16'h0020);
    @(negedge clk);
    chk(16'h0000, {15'h0, irq});
    rd(ADDR_IRQ_STATUS, 16'h00c8);
    // latched mode and narrow range
    wr(ADDR_CONFIG, 16'h0003);
    @(negedge clk);
    chk(16'h0001, {15'h0, range_sel});
    wr(ADDR_SHUNT_OVER, 16'h0010);
    hit(4'h1, 24'h000011);
    flg(8'he9);
    hit(4'h1, 24'h000010);
    flg(8'he9);
    rd(ADDR_DIAG, 16'h00e9);
    flg(8'h01);
    // both shunt limits negative, over kept as the larger: a result between trips neither
    wr(ADDR_SHUNT_UNDER, 16'hff00);
    wr(ADDR_SHUNT_OVER, 16'hfff0);
    hit(4'h1, 24'h00ff80);
    flg(8'h01);
    wr(ADDR_POWER_OVER, 16'h0100);
    hit(4'h8, 24'h010100);
    flg(8'h05);
    // bus over limit written with bit 15 high, so only the low fifteen bits compare
    wr(ADDR_BUS_OVER, 16'h8100);
    hit(4'ha, 24'h010101);
    flg(8'h1d);
    // checksum error drops the trim bit, which software cannot restore
    @(posedge clk);
    trim_checksum_error <= 1'b1;
    @(posedge clk);
    trim_checksum_error <= 1'b0;
    flg(8'h1c);
    wr(ADDR_DIAG, 16'hffff);
    rd(ADDR_DIAG, 16'h001c);
    flg(8'h00);
    // a reset in mid-run brings back the trim bit and the wide range
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_DIAG, 16'h0001);
    chk(16'h0000, {15'h0, range_sel});
    final_report();
  end
endmodule

`default_nettype wire
